// File: sfu_pkg.sv
// Purpose: Shared constants and types for the serial flash update block
// Assumes: 20 MHz core clock, 38400 bps 8N1 serial link
// Notes:   Offsets and counts used by sfu_top live here, except literals such as the 512-page limit
package sfu_pkg;
  localparam int unsigned CLK_HZ        = 20000000;
  localparam int unsigned BAUD_BPS      = 38400;
  localparam int unsigned BIT_CYC       = CLK_HZ / BAUD_BPS;
  localparam int unsigned HALF_CYC      = BIT_CYC / 2;
  localparam int unsigned DATA_BITS     = 8;
  localparam int unsigned PAGE_BYTES    = 128;
  localparam int unsigned ERASE_BLOCKS  = 3;
  localparam int unsigned ERASE_CYC     = 64;
  localparam int unsigned PROG_CYC      = 32;
  localparam int unsigned DL_CYC        = 16;

  localparam logic [7:0] CMD_PROG_REQ   = 8'h55;
  localparam logic [7:0] CMD_ERASE_DONE = 8'h66;
  localparam logic [7:0] CMD_DATA_REQ   = 8'h77;
  localparam logic [7:0] CMD_PROG_OK    = 8'hAA;
  localparam logic [7:0] FLASH_KEY_VAL  = 8'hA5;

  localparam logic [3:0] ADDR_CODE_CTRL = 4'h0;
  localparam logic [3:0] ADDR_KEY       = 4'h1;
  localparam logic [3:0] ADDR_SYSCTL2   = 4'h2;
  localparam logic [3:0] ADDR_RAMEMU    = 4'h3;
  localparam logic [3:0] ADDR_STATUS    = 4'h4;
  localparam logic [3:0] ADDR_TIMER0    = 4'h8;

  localparam logic [7:0] CODE_CTRL_RST  = 8'h80;
  localparam int unsigned BIT_FAULT     = 4;
  localparam int unsigned BIT_DL_REQ    = 0;
  localparam int unsigned BIT_WIN_EN    = 0;
  localparam logic [7:0] TIMER_LO_ADDR  = 8'h80;
  localparam logic [7:0] TIMER_HI_ADDR  = 8'hB1;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfu_bus_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ERASE = 3'b001,
    ST_EACK  = 3'b011,
    ST_DREQ  = 3'b010,
    ST_RECV  = 3'b110,
    ST_PROG  = 3'b111,
    ST_DONE  = 3'b101
  } sfu_state_t;
endpackage

// File: sfu_props.sv
// Purpose: Port properties of the serial flash update block
// Assumes: One clock, sync active-high reset
// Notes:   Bound to sfu_top after the module
module sfu_props_chk (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        sys_rst,
  // Inputs
  input wire logic        hw_standby,
  input wire logic        mode_sel_2,
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_rd,
  input wire logic        flash_error,
  // Outputs
  input wire logic        serial_txd,
  input wire logic [7:0]  reg_rdata,
  input wire logic        irq_mask,
  input wire logic        flash_busy,
  input wire logic [15:0] prog_addr,
  input wire logic        prog_strobe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  sequence code_rd;
    $past(reg_rd) && $past(reg_addr) == 8'h00;
  endsequence
  sequence start_bit;
    ##260 !serial_txd ##259 !serial_txd;
  endsequence
  chk_busy_masks: assert property (flash_busy |-> irq_mask)
    else $error("irq mask low during flash work");
  chk_code_fixed: assert property (code_rd |-> reg_rdata == 8'h00 ||
    (reg_rdata[7] && reg_rdata[6:5] == 2'b00 && !reg_rdata[0]))
    else $error("code control fixed bits wrong");
  chk_gate_read: assert property ($past(reg_rd) &&
    !$past(mode_sel_2, 3) && $past(reg_addr) inside {8'h00, 8'h01}
    |-> reg_rdata == 8'h00)
    else $error("gated register read not zero");
  chk_rdata_hold: assert property (!$past(reg_rd) && !$past(hw_standby)
    |-> $stable(reg_rdata))
    else $error("read data moved without read");
  chk_bit_time: assert property ($fell(serial_txd) |-> start_bit)
    else $error("serial bit shorter than bit time");
  chk_page_align: assert property (prog_strobe |-> prog_addr[6:0] == 7'h00)
    else $error("page address not 128 aligned");
  chk_fault_stop: assert property (flash_busy && flash_error
    |-> ##[1:2] !flash_busy)
    else $error("flash fault did not stop operation");
  chk_erase_span: assert property ($rose(flash_busy)
    |-> flash_busy[*8] ##24 flash_busy)
    else $error("flash operation cut short");
endmodule // sfu_props_chk

bind sfu_top sfu_props_chk u_chk (.core_clk(core_clk), .sys_rst(sys_rst),
  .hw_standby(hw_standby), .mode_sel_2(mode_sel_2), .reg_addr(reg_addr),
  .reg_rd(reg_rd), .flash_error(flash_error), .serial_txd(serial_txd),
  .reg_rdata(reg_rdata), .irq_mask(irq_mask), .flash_busy(flash_busy),
  .prog_addr(prog_addr), .prog_strobe(prog_strobe));

// File: sfu_tool_model.sv
// Purpose: Programming tool at the far end of the serial link
// Assumes: 8N1 framing at 38400 bps
// Notes:   Received bytes queue up in got
module sfu_tool_model (
  // Serial link
  input  wire logic serial_txd,
  output logic      serial_rxd
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BIT_NS = 26042;
  logic [7:0] got[$];
  int         frame_err;
  initial begin
    serial_rxd = 1'b1;
    frame_err = 0;
  end
  task automatic send_byte(input logic [7:0] b);
    serial_rxd = 1'b0;
    #BIT_NS;
    for (int i = 0; i < 8; i++) begin
      serial_rxd = b[i];
      #BIT_NS;
    end
    serial_rxd = 1'b1;
    #BIT_NS;
  endtask
  always @(negedge serial_txd) begin : rx_frame
    logic [7:0] b;
    #(BIT_NS / 2);
    if (serial_txd === 1'b0) begin
      for (int i = 0; i < 8; i++) begin
        #BIT_NS;
        b[i] = serial_txd;
      end
      #BIT_NS;
      if (serial_txd !== 1'b1) frame_err++;
      got.push_back(b);
    end
  end
endmodule // sfu_tool_model

// File: sfu_top.sv
// Purpose: Serial flash update command handler with flash control regs
// Assumes: Async serial pin, byte-wide register port, one clock
// Notes:   Flash array is modelled by busy timers and a fault input
module sfu_top (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  // Standby entries
  input  wire logic        hw_standby,
  input  wire logic        sw_standby,
  // Mode pins
  input  wire logic        mode_sel_2,
  // Serial channel
  input  wire logic        serial_rxd,
  output logic             serial_txd,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // Flash array status
  input  wire logic        flash_error,
  output logic             irq_mask,
  output logic             flash_busy,
  output logic      [15:0] prog_addr,
  output logic             prog_strobe
);
  logic [1:0]  rx_sync_reg;
  logic [15:0] rx_cnt_reg;
  logic [3:0]  rx_bit_reg;
  logic [7:0]  rx_sh_reg;
  logic        rx_busy_reg;
  logic        rx_valid_reg;
  logic [15:0] tx_cnt_reg;
  logic [3:0]  tx_bit_reg;
  logic [9:0]  tx_sh_reg;
  logic        tx_start;
  logic [7:0]  tx_byte;
  logic        tx_busy;
  logic [7:0]  ram_mem [sfu_pkg::PAGE_BYTES];
  logic [6:0]  ram_idx_reg;
  logic [15:0] op_cnt_reg;
  logic [1:0]  blk_reg;
  logic        fault_reg;
  logic        dl_reg;
  logic [7:0]  key_reg;
  logic        win_en_reg;
  logic        ramemu_reg;
  logic [7:0]  timer_reg;
  logic [1:0]  mode_sync_reg;
  logic        rst_all;
  logic        flash_acc;
  sfu_pkg::sfu_bus_t bus;
  sfu_pkg::sfu_state_t state_reg;
  sfu_pkg::sfu_state_t state_next;

  function automatic logic in_timer(input logic [7:0] a);
    return a >= sfu_pkg::TIMER_LO_ADDR && a <= sfu_pkg::TIMER_HI_ADDR;
  endfunction

  assign bus      = '{wr: reg_wr, rd: reg_rd, addr: reg_addr,
                      wdata: reg_wdata};
  assign rst_all  = sys_rst | hw_standby;
  assign flash_acc = win_en_reg & mode_sync_reg[1];
  assign flash_busy = state_reg == sfu_pkg::ST_ERASE ||
                      state_reg == sfu_pkg::ST_PROG;
  assign irq_mask = flash_busy | dl_reg;

  // Pin synchronisers, then the 8N1 receiver
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      {mode_sync_reg, rx_sync_reg} <= 4'h3;
    end else begin
      {mode_sync_reg, rx_sync_reg} <= {mode_sync_reg[0], mode_sel_2,
                                       rx_sync_reg[0], serial_rxd};
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst_all) begin
      rx_cnt_reg   <= 16'h0000;
      rx_bit_reg   <= 4'h0;
      rx_sh_reg    <= 8'h00;
      rx_busy_reg  <= 1'b0;
      rx_valid_reg <= 1'b0;
    end else begin
      rx_valid_reg <= 1'b0;
      if (!rx_busy_reg) begin
        if (!rx_sync_reg[1]) begin
          rx_busy_reg <= 1'b1;
          rx_cnt_reg  <= 16'(sfu_pkg::HALF_CYC);
          rx_bit_reg  <= 4'h0;
        end
      end else if (rx_cnt_reg != 16'h0000) begin
        rx_cnt_reg <= rx_cnt_reg - 16'h0001;
      end else begin
        rx_cnt_reg <= 16'(sfu_pkg::BIT_CYC - 1);
        rx_bit_reg <= rx_bit_reg + 4'h1;
        if (rx_bit_reg == 4'h0 && rx_sync_reg[1]) begin
          rx_busy_reg <= 1'b0;
        end else if (rx_bit_reg == 4'(sfu_pkg::DATA_BITS + 1)) begin
          rx_busy_reg  <= 1'b0;
          rx_valid_reg <= rx_sync_reg[1];
        end else if (rx_bit_reg != 4'h0) begin
          rx_sh_reg <= {rx_sync_reg[1], rx_sh_reg[7:1]};
        end
      end
    end
  end

  // Transmitter
  assign tx_busy = tx_bit_reg != 4'h0;
  always_ff @(posedge core_clk) begin
    if (rst_all) begin
      tx_cnt_reg <= 16'h0000;
      tx_bit_reg <= 4'h0;
      tx_sh_reg  <= 10'h3FF;
    end else if (tx_start && !tx_busy) begin
      tx_sh_reg  <= {1'b1, tx_byte, 1'b0};
      tx_bit_reg <= 4'hA;
      tx_cnt_reg <= 16'(sfu_pkg::BIT_CYC - 1);
    end else if (tx_busy) begin
      if (tx_cnt_reg != 16'h0000) begin
        tx_cnt_reg <= tx_cnt_reg - 16'h0001;
      end else begin
        tx_cnt_reg <= 16'(sfu_pkg::BIT_CYC - 1);
        tx_bit_reg <= tx_bit_reg - 4'h1;
        tx_sh_reg  <= {1'b1, tx_sh_reg[9:1]};
      end
    end
  end
  assign serial_txd = tx_sh_reg[0];

  // Command sequencer
  always_comb begin
    state_next = state_reg;
    tx_start   = 1'b0;
    tx_byte    = sfu_pkg::CMD_DATA_REQ;
    unique case (state_reg)
      sfu_pkg::ST_IDLE: begin
        if (rx_valid_reg && rx_sh_reg == sfu_pkg::CMD_PROG_REQ &&
            !fault_reg) begin
          state_next = sfu_pkg::ST_ERASE;
        end
      end
      sfu_pkg::ST_ERASE: begin
        if (op_cnt_reg == 16'h0000 &&
            blk_reg == 2'(sfu_pkg::ERASE_BLOCKS - 1)) begin
          state_next = sfu_pkg::ST_EACK;
        end
      end
      sfu_pkg::ST_EACK: begin
        tx_start = 1'b1;
        tx_byte  = sfu_pkg::CMD_ERASE_DONE;
        if (!tx_busy) begin
          state_next = sfu_pkg::ST_DREQ;
        end
      end
      sfu_pkg::ST_DREQ: begin
        tx_start = 1'b1;
        tx_byte  = sfu_pkg::CMD_DATA_REQ;
        if (!tx_busy) begin
          state_next = sfu_pkg::ST_RECV;
        end
      end
      sfu_pkg::ST_RECV: begin
        if (rx_valid_reg && ram_idx_reg == 7'h7F) begin
          state_next = sfu_pkg::ST_PROG;
        end
      end
      sfu_pkg::ST_PROG: begin
        if (op_cnt_reg == 16'h0000) begin
          state_next = (prog_addr[15:7] == 9'h1FF) ? sfu_pkg::ST_DONE
                                                   : sfu_pkg::ST_DREQ;
        end
      end
      sfu_pkg::ST_DONE: begin
        tx_start = 1'b1;
        tx_byte  = sfu_pkg::CMD_PROG_OK;
        if (!tx_busy) begin
          state_next = sfu_pkg::ST_IDLE;
        end
      end
      default: state_next = sfu_pkg::ST_IDLE;
    endcase
    if (fault_reg && flash_busy) begin
      state_next = sfu_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst_all) begin
      state_reg <= sfu_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Operation timers, erase blocks and program address
  always_ff @(posedge core_clk) begin
    if (rst_all) begin
      op_cnt_reg  <= 16'h0000;
      blk_reg     <= 2'h0;
      prog_addr   <= 16'h0000;
      prog_strobe <= 1'b0;
    end else begin
      prog_strobe <= 1'b0;
      if (state_reg == sfu_pkg::ST_IDLE &&
          state_next == sfu_pkg::ST_ERASE) begin
        op_cnt_reg <= 16'(sfu_pkg::ERASE_CYC - 1);
        blk_reg    <= 2'h0;
        prog_addr  <= 16'h0000;
      end else if (state_reg == sfu_pkg::ST_ERASE) begin
        if (op_cnt_reg != 16'h0000) begin
          op_cnt_reg <= op_cnt_reg - 16'h0001;
        end else if (state_next == sfu_pkg::ST_ERASE) begin
          blk_reg    <= blk_reg + 2'h1;
          op_cnt_reg <= 16'(sfu_pkg::ERASE_CYC - 1);
        end
      end else if (state_reg == sfu_pkg::ST_RECV &&
                   state_next == sfu_pkg::ST_PROG) begin
        op_cnt_reg  <= 16'(sfu_pkg::PROG_CYC - 1);
        prog_strobe <= 1'b1;
      end else if (state_reg == sfu_pkg::ST_PROG) begin
        if (op_cnt_reg != 16'h0000) begin
          op_cnt_reg <= op_cnt_reg - 16'h0001;
        end else begin
          prog_addr <= prog_addr + 16'(sfu_pkg::PAGE_BYTES);
        end
      end
    end
  end

  // Page buffer
  always_ff @(posedge core_clk) begin
    if (rst_all || state_reg == sfu_pkg::ST_DREQ) begin
      ram_idx_reg <= 7'h00;
    end else if (state_reg == sfu_pkg::ST_RECV && rx_valid_reg) begin
      ram_idx_reg <= ram_idx_reg + 7'h01;
    end
  end

  always_ff @(posedge core_clk) begin
    if (state_reg == sfu_pkg::ST_RECV && rx_valid_reg) begin
      ram_mem[ram_idx_reg] <= rx_sh_reg;
    end
  end

  // Fault flag survives software standby
  always_ff @(posedge core_clk) begin
    if (rst_all) begin
      fault_reg <= 1'b0;
    end else if (flash_error && flash_busy) begin
      fault_reg <= 1'b1;
    end
  end

  // Byte registers, cleared by reset or any standby
  always_ff @(posedge core_clk) begin
    if (rst_all || sw_standby) begin
      key_reg    <= 8'h00;
      win_en_reg <= 1'b0;
      ramemu_reg <= 1'b0;
      timer_reg  <= 8'h00;
    end else if (bus.wr) begin
      if (bus.addr == {4'h0, sfu_pkg::ADDR_KEY} && flash_acc) begin
        key_reg <= bus.wdata;
      end
      if (bus.addr == {4'h0, sfu_pkg::ADDR_SYSCTL2}) begin
        win_en_reg <= bus.wdata[sfu_pkg::BIT_WIN_EN];
      end
      if (bus.addr == {4'h0, sfu_pkg::ADDR_RAMEMU}) begin
        ramemu_reg <= bus.wdata[0];
      end
      if (in_timer(bus.addr) && !win_en_reg) begin
        timer_reg <= bus.wdata;
      end
    end
  end

  // Download request, self-clearing
  always_ff @(posedge core_clk) begin
    if (rst_all || sw_standby) begin
      dl_reg <= 1'b0;
    end else if (bus.wr && flash_acc && !dl_reg &&
                 bus.addr == {4'h0, sfu_pkg::ADDR_CODE_CTRL} &&
                 bus.wdata[sfu_pkg::BIT_DL_REQ] && !ramemu_reg &&
                 key_reg == sfu_pkg::FLASH_KEY_VAL) begin
      dl_reg <= 1'b1;
    end else if (dl_reg && op_cnt_reg == 16'h0000 && !flash_busy) begin
      dl_reg <= 1'b0;
    end
  end

  // Read port, byte wide, data one cycle later
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (bus.rd) begin
      reg_rdata <= 8'h00;
      if (bus.addr == {4'h0, sfu_pkg::ADDR_CODE_CTRL} && flash_acc) begin
        reg_rdata <= {1'b1, 2'b00, fault_reg, 4'h0};
      end else if (bus.addr == {4'h0, sfu_pkg::ADDR_KEY} && flash_acc) begin
        reg_rdata <= key_reg;
      end else if (bus.addr == {4'h0, sfu_pkg::ADDR_SYSCTL2}) begin
        reg_rdata <= {7'h00, win_en_reg};
      end else if (bus.addr == {4'h0, sfu_pkg::ADDR_RAMEMU}) begin
        reg_rdata <= {7'h00, ramemu_reg};
      end else if (bus.addr == {4'h0, sfu_pkg::ADDR_STATUS}) begin
        reg_rdata <= {mode_sync_reg[1], dl_reg, 3'h0, state_reg};
      end else if (in_timer(bus.addr) && !win_en_reg) begin
        reg_rdata <= timer_reg;
      end
    end
  end
endmodule // sfu_top

// File: test_serial_flash_update_protocol.sv
// Purpose: Self-checking bench for sfu_top
// Assumes: Tool model drives the serial input
// Notes:   Full 512-page run is too long; flow checked up to data request
module test_serial_flash_update_protocol;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] exp;
  } sfu_row_t;
  localparam sfu_row_t ROWS [8] = '{
    '{1'b0, 8'h00, 8'h00, 8'h00}, '{1'b1, 8'h02, 8'h01, 8'h01},
    '{1'b1, 8'h00, 8'hE6, 8'h80}, '{1'b1, 8'h80, 8'h5A, 8'h00},
    '{1'b1, 8'hFF, 8'h12, 8'h00}, '{1'b1, 8'h01, 8'hA5, 8'hA5},
    '{1'b1, 8'h02, 8'h00, 8'h00}, '{1'b1, 8'h80, 8'h5A, 8'h5A}};
  logic        core_clk, sys_rst, hw_standby, sw_standby, mode_sel_2;
  logic        serial_rxd, serial_txd, reg_wr, reg_rd, flash_error;
  logic        irq_mask, flash_busy, prog_strobe;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic [15:0] prog_addr;
  int          err_total, cmp_count;
  sfu_top dut (.core_clk(core_clk), .sys_rst(sys_rst),
    .hw_standby(hw_standby), .sw_standby(sw_standby),
    .mode_sel_2(mode_sel_2), .serial_rxd(serial_rxd),
    .serial_txd(serial_txd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .flash_error(flash_error), .irq_mask(irq_mask),
    .flash_busy(flash_busy), .prog_addr(prog_addr),
    .prog_strobe(prog_strobe));
  sfu_tool_model tool (.serial_txd(serial_txd), .serial_rxd(serial_rxd));
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic check(string n, logic [7:0] seen, logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic reg_write(logic [7:0] a, logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_check(string n, logic [7:0] a, logic [7:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 check(n, reg_rdata, e);
  endtask
  function automatic bit ev_hit(int kind, int k);
    case (kind)
      0: return flash_busy === 1'b1;
      1: return flash_busy === 1'b0;
      default: return tool.got.size() >= k;
    endcase
  endfunction
  task automatic wait_ev(int kind, int k, int lim);
    int n;
    n = 0;
    while (!ev_hit(kind, k) && n < lim) begin
      @(posedge core_clk);
      #1 n++;
    end
    if (n >= lim) begin
      err_total++;
      $display("[ERR] wait kind %0d ran out", kind);
      tally_and_finish();
    end
  endtask
  task automatic do_reset();
    sys_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    #1 check("idle txd", {7'h00, serial_txd}, 8'h01);
    check("idle mask", {7'h00, irq_mask}, 8'h00);
    check("reset page hi", prog_addr[15:8], 8'h00);
    check("reset page lo", {prog_addr[7:1], prog_strobe}, 8'h00);
  endtask
  initial begin
    {sys_rst, hw_standby, sw_standby, reg_wr, reg_rd, flash_error} = '0;
    {reg_addr, reg_wdata} = '0;
    mode_sel_2 = 1'b1;
    err_total = 0;
    cmp_count = 0;
    do_reset();
    foreach (ROWS[i]) begin
      if (ROWS[i].wr) reg_write(ROWS[i].addr, ROWS[i].wdata);
      reg_check("row read", ROWS[i].addr, ROWS[i].exp);
    end
    $display("test register rows done");
    reg_write(8'h02, 8'h01);
    reg_write(8'h03, 8'h00);
    reg_write(8'h01, 8'hA5);
    reg_write(8'h00, 8'h81);
    #1 check("download mask", {7'h00, irq_mask}, 8'h01);
    repeat (40) @(posedge core_clk);
    reg_check("download bit", 8'h00, 8'h80);
    @(posedge core_clk);
    mode_sel_2 <= 1'b0;
    repeat (2) @(posedge core_clk);
    reg_check("mode gate", 8'h00, 8'h00);
    @(posedge core_clk);
    mode_sel_2 <= 1'b1;
    $display("test download done");
    fork tool.send_byte(sfu_pkg::CMD_PROG_REQ); join_none
    wait_ev(0, 0, 8000);
    check("erase mask", {7'h00, irq_mask}, 8'h01);
    wait_ev(2, 2, 20000);
    check("erase done", tool.got[0], sfu_pkg::CMD_ERASE_DONE);
    check("data req", tool.got[1], sfu_pkg::CMD_DATA_REQ);
    check("framing", 8'(tool.frame_err), 8'h00);
    $display("test command flow done");
    @(posedge core_clk);
    do_reset();
    fork tool.send_byte(sfu_pkg::CMD_PROG_REQ); join_none
    wait_ev(0, 0, 8000);
    repeat (100) @(posedge core_clk);
    flash_error <= 1'b1;
    wait_ev(1, 0, 10);
    @(posedge core_clk);
    flash_error <= 1'b0;
    repeat (400) @(posedge core_clk);
    reg_write(8'h02, 8'h01);
    reg_check("fault flag", 8'h00, 8'h90);
    tool.send_byte(sfu_pkg::CMD_PROG_REQ);
    repeat (2000) @(posedge core_clk);
    check("no reply", 8'(tool.got.size()), 8'h02);
    reg_check("state idle", 8'h04, 8'h80);
    @(posedge core_clk);
    sw_standby <= 1'b1;
    @(posedge core_clk);
    sw_standby <= 1'b0;
    reg_check("window clear", 8'h02, 8'h00);
    reg_write(8'h02, 8'h01);
    reg_check("fault kept", 8'h00, 8'h90);
    @(posedge core_clk);
    hw_standby <= 1'b1;
    @(posedge core_clk);
    hw_standby <= 1'b0;
    reg_write(8'h02, 8'h01);
    reg_check("fault cleared", 8'h00, 8'h80);
    $display("test fault and standby done");
    tally_and_finish();
  end
endmodule // test_serial_flash_update_protocol
